// *** design/gpc_pin_config.sv ***
// Purpose: Pin configuration, pad control and edge interrupts of ports 0 and 1
// Assumes: Single 100 MHz clock, synchronous active-high reset
// Notes:   Pads resolve wires outside; drv_n low means driven
`timescale 1ns/1ns
`default_nettype none
// Function
// RL1: Interrupt enable bit gates pin interrupt
// RL2: Edge interrupts; shared source rearms when all clear
// RL3: Driven output state can fire interrupt
// RL4: Active-low selects falling edge, else rising
// RL5: Threshold bit selects TTL or CMOS
// RL6: Open drain: data 1 floats, 0 drives low
// RL7: Push-pull drives both levels from data
// RL8: Pull-up bit connects pin pull-up
// RL9: Output enable turns driver on or off
// RL10: Alternate select off hands pin to GPIO
// RL11: Low-voltage drive only; regulator untouched
// RL12: External pins give own edge interrupts
// RL13: Software clears output enable for inputs
// RL14: Settings govern external pins in both uses
// RL15: Software disables source before changing polarity
// RL16: Plus data pin config inactive during USB
// RL17: Plus data pin is open drain only
// RL18: Bit 1 enables pull-ups on both pins
// RL19: Software clears USB pin enables before sleep
// RL20: Minus data pin config inactive during USB
// RL21: Pin 0.1 config layout, reset zero
// RL22: Pin 0.7 config layout, reserved bits
// RL23: USB pins follow data only without USB
// RL24: Data read gives pins, write sets drive
// RL25: Pin inputs double-synchronised before edges
// RL26: Reserved bits read zero, writes ignored
module gpc_pin_config (
  input  wire logic                               sys_clk,
  input  wire logic                               rst,
  input  wire logic [7:0]                         addr,
  input  wire logic [7:0]                         wdata,
  input  wire logic                               wr_en,
  input  wire logic                               rd_en,
  output var  logic [7:0]                         rdata,
  input  wire logic [gpc_pkg::NPINS-1:0]          pad_in,
  output var  gpc_pkg::gpc_pad_s [gpc_pkg::NPINS-1:0] pad_ctl,
  input  wire logic                               usb_enable,
  output var  logic                               usb_pins_pullup_on,
  input  wire logic                               spi_oe_req,
  input  wire logic                               spi_out,
  input  wire logic                               regulator_oe_req,
  output var  logic                               serial_out_pin_drv_n,
  output var  logic                               serial_out_pin_level,
  output var  logic                               serial_lv_drive,
  output var  logic                               regulator_output_pin_drv_n,
  output var  logic                               regulator_output_pin_level,
  output var  logic                               port_irq,
  output var  logic                               ext_int1_irq,
  output var  logic                               ext_int2_irq
);
  logic [7:0]              cfg [gpc_pkg::NPINS]; // Per-pin configuration
  logic [7:0]              alt_cfg;              // Alternate function control
  logic [gpc_pkg::NPINS-1:0] pin_data;           // Port data bits
  logic [gpc_pkg::NPINS-1:0] sync1;              // First sync stage
  logic [gpc_pkg::NPINS-1:0] sync2;              // Second sync stage
  logic [gpc_pkg::NPINS-1:0] act;                // Polarity-applied active level
  logic [gpc_pkg::NPINS-1:0] act_q;              // Active level last cycle
  logic                    shared_act;           // Any shared-source active
  logic                    shared_q;             // Shared level last cycle
  logic [gpc_pkg::NPINS-1:0] asserted;           // Active level of an enabled pin
  logic [gpc_pkg::NPINS-1:0] rise;               // Qualified edge this cycle
  logic                    shared_rise;          // Any shared-source edge

  // Write mask of each pin register
  function automatic logic [7:0] cfg_mask(input int idx);
    case (idx)
      gpc_pkg::PIN_P01:  cfg_mask = gpc_pkg::P01_MASK;
      gpc_pkg::PIN_INT1: cfg_mask = gpc_pkg::INT_MASK;
      gpc_pkg::PIN_INT2: cfg_mask = gpc_pkg::INT_MASK;
      gpc_pkg::PIN_P07:  cfg_mask = gpc_pkg::P07_MASK;
      gpc_pkg::PIN_DP:   cfg_mask = gpc_pkg::DP_MASK;
      default:           cfg_mask = gpc_pkg::DM_MASK;
    endcase
  endfunction : cfg_mask

  // Offset of each pin register
  function automatic logic [7:0] cfg_addr(input int idx);
    case (idx)
      gpc_pkg::PIN_P01:  cfg_addr = gpc_pkg::P01_CFG_ADDR;
      gpc_pkg::PIN_INT1: cfg_addr = gpc_pkg::INT1_CFG_ADDR;
      gpc_pkg::PIN_INT2: cfg_addr = gpc_pkg::INT2_CFG_ADDR;
      gpc_pkg::PIN_P07:  cfg_addr = gpc_pkg::P07_CFG_ADDR;
      gpc_pkg::PIN_DP:   cfg_addr = gpc_pkg::DP_CFG_ADDR;
      default:           cfg_addr = gpc_pkg::DM_CFG_ADDR;
    endcase
  endfunction : cfg_addr

  // Pad drive from enable, open drain and data
  function automatic logic [1:0] drive(input logic oe, input logic od,
                                       input logic dat);
    // {drv_n, level}; open drain floats a one
    if (!oe)
      drive = 2'h2;
    else if (od)
      drive = dat ? 2'h2 : 2'h0;
    else
      drive = {1'b0, dat};
  endfunction : drive

  // Configuration registers; masked bits never store
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < gpc_pkg::NPINS; i++)
        cfg[i] <= gpc_pkg::CFG_RESET; // RL21 RL22
      alt_cfg <= gpc_pkg::CFG_RESET;
    end
    else if (wr_en)
    begin
      for (int i = 0; i < gpc_pkg::NPINS; i++)
        if (addr == cfg_addr(i))
          cfg[i] <= wdata & cfg_mask(i); // RL26 RL21 RL22
      if (addr == gpc_pkg::ALT_CFG_ADDR)
        alt_cfg <= wdata & gpc_pkg::ALT_MASK;
    end
  end

  // Port data registers set the driven levels
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      pin_data <= '0;
    else if (wr_en && addr == gpc_pkg::PORT0_DATA_ADDR)
    begin
      pin_data[gpc_pkg::PIN_P01]  <= wdata[gpc_pkg::P0_BIT_P01]; // RL24
      pin_data[gpc_pkg::PIN_INT1] <= wdata[gpc_pkg::P0_BIT_INT1];
      pin_data[gpc_pkg::PIN_INT2] <= wdata[gpc_pkg::P0_BIT_INT2];
      pin_data[gpc_pkg::PIN_P07]  <= wdata[gpc_pkg::P0_BIT_P07];
    end
    else if (wr_en && addr == gpc_pkg::PORT1_DATA_ADDR)
    begin
      pin_data[gpc_pkg::PIN_DP] <= wdata[gpc_pkg::P1_BIT_DP]; // RL24
      pin_data[gpc_pkg::PIN_DM] <= wdata[gpc_pkg::P1_BIT_DM];
    end
  end

  // Read port; pins read as their synchronised state
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (rd_en)
    begin
      rdata <= 8'h00; // Unmapped offsets read zero
      for (int i = 0; i < gpc_pkg::NPINS; i++)
        if (addr == cfg_addr(i))
          rdata <= cfg[i];
      case (addr)
        gpc_pkg::PORT0_DATA_ADDR:
        begin
          rdata[gpc_pkg::P0_BIT_P01]  <= sync2[gpc_pkg::PIN_P01]; // RL24
          rdata[gpc_pkg::P0_BIT_INT1] <= sync2[gpc_pkg::PIN_INT1];
          rdata[gpc_pkg::P0_BIT_INT2] <= sync2[gpc_pkg::PIN_INT2];
          rdata[gpc_pkg::P0_BIT_P07]  <= sync2[gpc_pkg::PIN_P07];
        end
        gpc_pkg::PORT1_DATA_ADDR:
        begin
          rdata[gpc_pkg::P1_BIT_DP] <= sync2[gpc_pkg::PIN_DP];
          rdata[gpc_pkg::P1_BIT_DM] <= sync2[gpc_pkg::PIN_DM];
        end
        gpc_pkg::ALT_CFG_ADDR: rdata <= alt_cfg;
        default: ;
      endcase
    end
  end

  // Two-stage pin synchroniser; stage one feeds stage two only
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= pad_in;
      sync2 <= sync1; // RL25
    end
  end

  // Active level: pin state with polarity applied, never gated
  always_comb
  begin
    for (int i = 0; i < gpc_pkg::NPINS; i++)
    begin
      act[i]      = sync2[i] ^ cfg[i][gpc_pkg::B_ACT_LOW]; // RL4
      asserted[i] = act[i] & cfg[i][gpc_pkg::B_INT_EN]; // RL1
      // Enable gates the edge, so turning it on alone never fires
      rise[i]     = asserted[i] & ~act_q[i]; // RL1 RL3
    end
    // External pins are enabled in the interrupt controller
    rise[gpc_pkg::PIN_INT1] = act[gpc_pkg::PIN_INT1] & ~act_q[gpc_pkg::PIN_INT1]; // RL12
    rise[gpc_pkg::PIN_INT2] = act[gpc_pkg::PIN_INT2] & ~act_q[gpc_pkg::PIN_INT2]; // RL12
    // Shared line: any enabled source at its active level
    shared_act  = asserted[gpc_pkg::PIN_P01] | asserted[gpc_pkg::PIN_P07] |
                  asserted[gpc_pkg::PIN_DP] | asserted[gpc_pkg::PIN_DM];
    shared_rise = rise[gpc_pkg::PIN_P01] | rise[gpc_pkg::PIN_P07] |
                  rise[gpc_pkg::PIN_DP] | rise[gpc_pkg::PIN_DM];
  end

  // Edge detect: one pulse per selected edge on external lines, per rise from all idle on the shared line
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      act_q        <= '0;
      shared_q     <= 1'b0;
      port_irq     <= 1'b0;
      ext_int1_irq <= 1'b0;
      ext_int2_irq <= 1'b0;
    end
    else
    begin
      act_q    <= act;
      shared_q <= shared_act;
      // Shared line rearms only once every enabled source is idle
      port_irq     <= shared_rise & ~shared_q; // RL2
      ext_int1_irq <= rise[gpc_pkg::PIN_INT1]; // RL12
      ext_int2_irq <= rise[gpc_pkg::PIN_INT2]; // RL12
    end
  end

  // Port 0 pad controls; same for interrupt or GPIO use
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      pad_ctl <= {gpc_pkg::NPINS{5'h18}};
    else
    begin
      for (int i = gpc_pkg::PIN_P01; i <= gpc_pkg::PIN_P07; i++)
      begin
        {pad_ctl[i].drv_n, pad_ctl[i].level} <=
          drive(cfg[i][gpc_pkg::B_OE], cfg[i][gpc_pkg::B_OD], pin_data[i]); // RL6 RL7 RL9 RL14
        pad_ctl[i].pull_on <= cfg[i][gpc_pkg::B_PULL]; // RL8
        pad_ctl[i].ttl     <= cfg[i][gpc_pkg::B_TTL]; // RL5
        pad_ctl[i].hi_sink <= cfg[i][gpc_pkg::B_HSINK];
      end
      // USB pins: released to the transceiver while USB is on
      {pad_ctl[gpc_pkg::PIN_DP].drv_n, pad_ctl[gpc_pkg::PIN_DP].level} <=
        usb_enable ? 2'h2 :
        drive(cfg[gpc_pkg::PIN_DP][gpc_pkg::B_OE], 1'b1,
              pin_data[gpc_pkg::PIN_DP]); // RL16 RL17 RL23
      {pad_ctl[gpc_pkg::PIN_DM].drv_n, pad_ctl[gpc_pkg::PIN_DM].level} <=
        usb_enable ? 2'h2 :
        drive(cfg[gpc_pkg::PIN_DM][gpc_pkg::B_OE],
              cfg[gpc_pkg::PIN_DM][gpc_pkg::B_OD],
              pin_data[gpc_pkg::PIN_DM]); // RL20 RL23
      for (int i = gpc_pkg::PIN_DP; i <= gpc_pkg::PIN_DM; i++)
      begin
        pad_ctl[i].pull_on <= 1'b0;
        pad_ctl[i].ttl     <= 1'b0;
        pad_ctl[i].hi_sink <= 1'b0;
      end
    end
  end

  // Shared 5K pull-up of both data pins
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      usb_pins_pullup_on <= 1'b0;
    else
      usb_pins_pullup_on <= ~usb_enable &
                            cfg[gpc_pkg::PIN_DP][gpc_pkg::B_PULL]; // RL18 RL16
  end

  // Alternate function pins; select clear means GPIO owns the pad
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      serial_out_pin_drv_n       <= 1'b1;
      serial_out_pin_level       <= 1'b0;
      serial_lv_drive            <= 1'b0;
      regulator_output_pin_drv_n <= 1'b1;
      regulator_output_pin_level <= 1'b0;
    end
    else
    begin
      if (alt_cfg[gpc_pkg::A_SER_SEL])
      begin
        serial_out_pin_drv_n <= ~spi_oe_req; // RL10
        serial_out_pin_level <= spi_out;
      end
      else
      begin
        serial_out_pin_drv_n <= ~alt_cfg[gpc_pkg::A_SER_OE]; // RL10
        serial_out_pin_level <= alt_cfg[gpc_pkg::A_SER_DAT];
      end
      // Only the high-level source moves; regulator stays as set
      serial_lv_drive <= alt_cfg[gpc_pkg::A_LV_DRV]; // RL11
      if (alt_cfg[gpc_pkg::A_REG_SEL])
      begin
        regulator_output_pin_drv_n <= ~regulator_oe_req; // RL10
        regulator_output_pin_level <= 1'b0;
      end
      else
      begin
        regulator_output_pin_drv_n <= ~alt_cfg[gpc_pkg::A_REG_OE]; // RL10
        regulator_output_pin_level <= alt_cfg[gpc_pkg::A_REG_DAT];
      end
    end
  end

  // Checks
  a_irq_edge_cause: assert property (@(posedge sys_clk) disable iff (rst) // RL4
    ext_int1_irq |->
      ($past(sync2[gpc_pkg::PIN_INT1], 1) ^
       $past(cfg[gpc_pkg::PIN_INT1][gpc_pkg::B_ACT_LOW], 1)) &&
      !($past(sync2[gpc_pkg::PIN_INT1], 2) ^
        $past(cfg[gpc_pkg::PIN_INT1][gpc_pkg::B_ACT_LOW], 2)))
    else $error("ext int1 pulse without selected edge");
  a_int2_edge_cause: assert property (@(posedge sys_clk) disable iff (rst) // RL12
    ext_int2_irq |->
      ($past(sync2[gpc_pkg::PIN_INT2], 1) ^
       $past(cfg[gpc_pkg::PIN_INT2][gpc_pkg::B_ACT_LOW], 1)) &&
      !($past(sync2[gpc_pkg::PIN_INT2], 2) ^
        $past(cfg[gpc_pkg::PIN_INT2][gpc_pkg::B_ACT_LOW], 2)))
    else $error("ext int2 pulse without selected edge");
  a_irq_needs_enable: assert property (@(posedge sys_clk) disable iff (rst) // RL1
    port_irq |-> $past(shared_act, 1))
    else $error("port irq with no enabled source active");
  a_shared_held: assert property (@(posedge sys_clk) disable iff (rst) // RL2
    shared_act [*2] |=> !port_irq)
    else $error("shared irq rearmed while a source stayed active");
  a_irq_disabled: assert property (@(posedge sys_clk) disable iff (rst) // RL1
    (cfg[gpc_pkg::PIN_P01][gpc_pkg::B_INT_EN] == 1'b0 &&
     cfg[gpc_pkg::PIN_P07][gpc_pkg::B_INT_EN] == 1'b0 &&
     cfg[gpc_pkg::PIN_DP][gpc_pkg::B_INT_EN] == 1'b0 &&
     cfg[gpc_pkg::PIN_DM][gpc_pkg::B_INT_EN] == 1'b0) [*2] |=> !port_irq)
    else $error("port irq while all enables clear");
  a_irq_single: assert property (@(posedge sys_clk) disable iff (rst) // RL2
    port_irq |=> !port_irq)
    else $error("shared irq longer than one cycle");
  a_od_no_high: assert property (@(posedge sys_clk) disable iff (rst) // RL17
    !pad_ctl[gpc_pkg::PIN_DP].drv_n |-> !pad_ctl[gpc_pkg::PIN_DP].level)
    else $error("plus data pin driven high");
  a_usb_release: assert property (@(posedge sys_clk) disable iff (rst) // RL16
    usb_enable |=> pad_ctl[gpc_pkg::PIN_DP].drv_n && pad_ctl[gpc_pkg::PIN_DM].drv_n
      && !usb_pins_pullup_on)
    else $error("USB pins not released");
  a_oe_off: assert property (@(posedge sys_clk) disable iff (rst) // RL9
    !cfg[gpc_pkg::PIN_P01][gpc_pkg::B_OE] |=> pad_ctl[gpc_pkg::PIN_P01].drv_n)
    else $error("driver on with enable clear");
  a_od_float: assert property (@(posedge sys_clk) disable iff (rst) // RL6
    cfg[gpc_pkg::PIN_P07][gpc_pkg::B_OD] && pin_data[gpc_pkg::PIN_P07]
      |=> pad_ctl[gpc_pkg::PIN_P07].drv_n)
    else $error("open drain drove a one");
  a_rsvd_zero: assert property (@(posedge sys_clk) disable iff (rst) // RL26
    rd_en && addr == gpc_pkg::P07_CFG_ADDR |=> (rdata & ~gpc_pkg::P07_MASK) == 8'h00)
    else $error("reserved bits read nonzero");
  a_sync_depth: assert property (@(posedge sys_clk) disable iff (rst) // RL25
    ##2 sync2 == $past(pad_in, 2))
    else $error("synchroniser depth wrong");
  a_alt_ser_gpio: assert property (@(posedge sys_clk) disable iff (rst) // RL10
    !alt_cfg[gpc_pkg::A_SER_SEL] && !alt_cfg[gpc_pkg::A_SER_OE]
      |=> serial_out_pin_drv_n)
    else $error("serial pin driven with GPIO enable clear");
  a_alt_reg_gpio: assert property (@(posedge sys_clk) disable iff (rst) // RL10
    !alt_cfg[gpc_pkg::A_REG_SEL] && !alt_cfg[gpc_pkg::A_REG_OE]
      |=> regulator_output_pin_drv_n)
    else $error("regulator pin driven with GPIO enable clear");
  a_usb_pullup: assert property (@(posedge sys_clk) disable iff (rst) // RL18
    !usb_enable && cfg[gpc_pkg::PIN_DP][gpc_pkg::B_PULL] |=> usb_pins_pullup_on)
    else $error("USB pull-ups off with enable set");
  a_ttl_follow: assert property (@(posedge sys_clk) disable iff (rst) // RL5
    cfg[gpc_pkg::PIN_P01][gpc_pkg::B_TTL] |=> pad_ctl[gpc_pkg::PIN_P01].ttl)
    else $error("TTL threshold not applied");
endmodule : gpc_pin_config
`default_nettype wire

// *** design/gpc_pkg.sv ***
// Purpose: Shared constants and types for the pin configuration block
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   Pin index order is fixed by PIN_* constants below
package gpc_pkg;
  // Register offsets
  localparam logic [7:0] PORT0_DATA_ADDR = 8'h00;
  localparam logic [7:0] PORT1_DATA_ADDR = 8'h01;
  localparam logic [7:0] P01_CFG_ADDR    = 8'h06;
  localparam logic [7:0] INT1_CFG_ADDR   = 8'h08;
  localparam logic [7:0] INT2_CFG_ADDR   = 8'h09;
  localparam logic [7:0] P07_CFG_ADDR    = 8'h0C;
  localparam logic [7:0] DP_CFG_ADDR     = 8'h0D;
  localparam logic [7:0] DM_CFG_ADDR     = 8'h0E;
  localparam logic [7:0] ALT_CFG_ADDR    = 8'h18;
  // Writable bits per register; others read as zero
  localparam logic [7:0] P01_MASK  = 8'h7F;
  localparam logic [7:0] INT_MASK  = 8'h37;
  localparam logic [7:0] P07_MASK  = 8'h77;
  localparam logic [7:0] DP_MASK   = 8'h63;
  localparam logic [7:0] DM_MASK   = 8'h65;
  localparam logic [7:0] ALT_MASK  = 8'h7F;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Common configuration field positions
  localparam int B_INT_EN  = 6;
  localparam int B_ACT_LOW = 5;
  localparam int B_TTL     = 4;
  localparam int B_HSINK   = 3;
  localparam int B_OD      = 2;
  localparam int B_PULL    = 1;
  localparam int B_OE      = 0;
  // Alternate function register fields
  localparam int A_REG_SEL = 0;
  localparam int A_SER_SEL = 1;
  localparam int A_LV_DRV  = 2;
  localparam int A_SER_OE  = 3;
  localparam int A_SER_DAT = 4;
  localparam int A_REG_OE  = 5;
  localparam int A_REG_DAT = 6;
  // Pin indices
  localparam int PIN_P01 = 0;
  localparam int PIN_INT1 = 1;
  localparam int PIN_INT2 = 2;
  localparam int PIN_P07 = 3;
  localparam int PIN_DP  = 4;
  localparam int PIN_DM  = 5;
  localparam int NPINS   = 6;
  // Port data bit positions of each pin
  localparam int P0_BIT_P01  = 1;
  localparam int P0_BIT_INT1 = 3;
  localparam int P0_BIT_INT2 = 4;
  localparam int P0_BIT_P07  = 7;
  localparam int P1_BIT_DP   = 0;
  localparam int P1_BIT_DM   = 1;
  // Per-pin pad control
  typedef struct packed {
    logic drv_n;    // Low while the pad driver is on
    logic level;    // Level driven when on
    logic pull_on;  // Pull-up connected
    logic ttl;      // TTL input threshold
    logic hi_sink;  // Strong sink
  } gpc_pad_s;
endpackage : gpc_pkg

// *** verification/gpc_pad_model.sv ***
// Purpose: External circuitry on the port pins, seen from the pad side
// Assumes: Tester may drive any pin; pull-ups hold a released wire high
// Notes:   A wire nobody holds flips each cycle, so it never keeps a level
`timescale 1ns/1ns
`default_nettype none
module gpc_pad_model (
  input  wire logic                                   sys_clk,
  input  wire gpc_pkg::gpc_pad_s [gpc_pkg::NPINS-1:0] pad_ctl,
  input  wire logic                                   usb_pull,
  input  wire logic [gpc_pkg::NPINS-1:0]              ext_en,
  input  wire logic [gpc_pkg::NPINS-1:0]              ext_lvl,
  output var  logic [gpc_pkg::NPINS-1:0]              pad_in
);
  logic [gpc_pkg::NPINS-1:0] flip = '0;  // Stand-in for a floating wire

  // Changing pattern: the simulator must not settle a float for us
  always_ff @(posedge sys_clk)
  begin
    flip <= ~flip;
  end

  // Wire level: own driver wins, then tester, then pull-ups, else float
  always_comb
  begin
    for (int i = 0; i < gpc_pkg::NPINS; i++)
    begin
      if (!pad_ctl[i].drv_n)
        pad_in[i] = pad_ctl[i].level;
      else if (ext_en[i])
        pad_in[i] = ext_lvl[i];
      else if (pad_ctl[i].pull_on || (usb_pull && i >= gpc_pkg::PIN_DP))
        pad_in[i] = 1'b1;
      else
        pad_in[i] = flip[i];
    end
  end
endmodule : gpc_pad_model
`default_nettype wire

// *** verification/gpc_pin_config_test.sv ***
// Purpose: Self-checking bench for the pin configuration block
// Assumes: One-cycle register strobes, pads resolved by the pad model
// Notes:   Tester holds every pin low unless a scenario raises or releases it
`timescale 1ns/1ns
`default_nettype none
module gpc_pin_config_test;
  logic                                   sys_clk = 1'b0;  // 100 MHz
  logic                                   rst = 1'b1;      // Sync reset
  logic [7:0]                             addr = 8'h00;
  logic [7:0]                             wdata = 8'h00;
  logic                                   wr_en = 1'b0;
  logic                                   rd_en = 1'b0;
  logic [7:0]                             rdata;
  logic [gpc_pkg::NPINS-1:0]              pad_in;
  gpc_pkg::gpc_pad_s [gpc_pkg::NPINS-1:0] pad_ctl;
  logic                                   usb_enable = 1'b0;
  logic                                   spi_oe_req = 1'b0;
  logic                                   spi_out = 1'b0;
  logic                                   reg_oe = 1'b0;
  logic                                   usb_pull, ser_drv_n, ser_lvl, lv_drv;
  logic                                   regp_drv_n, regp_lvl, port_irq, irq1, irq2;
  logic [gpc_pkg::NPINS-1:0]              ext_en = '1;     // Tester drives pin
  logic [gpc_pkg::NPINS-1:0]              ext_lvl = '0;    // Tester level
  int                                     n_mismatch = 0;
  int                                     checked = 0;
  wire logic [2:0]                        irqs = {irq2, irq1, port_irq};

  gpc_pin_config DUT (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pad_in(pad_in), .pad_ctl(pad_ctl),
    .usb_enable(usb_enable), .usb_pins_pullup_on(usb_pull), .spi_oe_req(spi_oe_req),
    .spi_out(spi_out), .regulator_oe_req(reg_oe), .serial_out_pin_drv_n(ser_drv_n),
    .serial_out_pin_level(ser_lvl), .serial_lv_drive(lv_drv),
    .regulator_output_pin_drv_n(regp_drv_n), .regulator_output_pin_level(regp_lvl),
    .port_irq(port_irq), .ext_int1_irq(irq1), .ext_int2_irq(irq2));
  gpc_pad_model u_pads (.sys_clk(sys_clk), .pad_ctl(pad_ctl), .usb_pull(usb_pull),
    .ext_en(ext_en), .ext_lvl(ext_lvl), .pad_in(pad_in));

  // Free-running clock
  initial
    forever #5 sys_clk = ~sys_clk;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Single-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask : wr

  // Read data stand from the cycle after the strobe until the next read
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 chk(what, exp, rdata);
  endtask : rd_chk

  // Pad state lands two edges after its cause
  task automatic pad_chk(input string what, input int p, input logic [1:0] exp);
    repeat (3) @(posedge sys_clk);
    #1 chk(what, {6'h00, exp}, {6'h00, pad_ctl[p].drv_n, pad_ctl[p].level});
  endtask : pad_chk

  task automatic pin(input int i, input logic v);
    @(posedge sys_clk);
    ext_lvl[i] <= v;
  endtask : pin

  // Pulses counted over a window wider than the sync plus edge delay
  task automatic cnt_chk(input string what, input int sel, input logic [7:0] exp);
    int c;
    c = 0;
    repeat (8)
    begin
      @(posedge sys_clk);
      #1 if (irqs[sel] !== 1'b0) c++;
    end
    chk(what, exp, c[7:0]);
  endtask : cnt_chk

  task automatic t_regs;
    logic [7:0] a [7] = '{8'h06, 8'h08, 8'h09, 8'h0C, 8'h0D, 8'h0E, 8'h18};
    logic [7:0] m [7] = '{gpc_pkg::P01_MASK, gpc_pkg::INT_MASK, gpc_pkg::INT_MASK,
      gpc_pkg::P07_MASK, gpc_pkg::DP_MASK, gpc_pkg::DM_MASK, gpc_pkg::ALT_MASK};
    for (int i = 0; i < 7; i++)
    begin
      rd_chk("cfg reset", a[i], gpc_pkg::CFG_RESET);
      wr(a[i], 8'hFF);
      rd_chk("cfg mask", a[i], m[i]);
      wr(a[i], 8'h00);
    end
    wr(8'h3F, 8'hFF);
    rd_chk("unmapped", 8'h3F, 8'h00);
  endtask : t_regs

  task automatic t_pads;
    ext_en[0] <= 1'b0;
    wr(8'h06, 8'h01);
    wr(8'h00, 8'h02);
    pad_chk("p01 push high", 0, 2'b01);
    wr(8'h00, 8'h00);
    pad_chk("p01 push low", 0, 2'b00);
    wr(8'h06, 8'h05);
    pad_chk("p01 od low", 0, 2'b00);
    wr(8'h00, 8'h02);
    repeat (3) @(posedge sys_clk);
    #1 chk("p01 od float", 8'h01, {7'h00, pad_ctl[0].drv_n});
    wr(8'h06, 8'h1A);
    repeat (3) @(posedge sys_clk);
    #1 chk("p01 in", 8'h0F, {4'h0, pad_ctl[0].drv_n, pad_ctl[0].pull_on,
      pad_ctl[0].ttl, pad_ctl[0].hi_sink});
    rd_chk("port0 pins", 8'h00, 8'h02);
    ext_en[0] <= 1'b1;
    wr(8'h06, 8'h00);
    wr(8'h00, 8'h00);
  endtask : t_pads

  task automatic t_irq;
    wr(8'h06, 8'h40);
    wr(8'h0C, 8'h40);
    pin(0, 1'b1);
    cnt_chk("p01 rise", 0, 8'h01);
    pin(3, 1'b1);
    cnt_chk("shared held", 0, 8'h00);
    pin(0, 1'b0);
    pin(3, 1'b0);
    cnt_chk("fall ignored", 0, 8'h00);
    pin(3, 1'b1);
    cnt_chk("shared rearm", 0, 8'h01);
    pin(3, 1'b0);
    wr(8'h0C, 8'h00);
    wr(8'h06, 8'h20);
    wr(8'h06, 8'h60);
    pin(0, 1'b1);
    cnt_chk("rise ignored", 0, 8'h00);
    pin(0, 1'b0);
    cnt_chk("p01 fall", 0, 8'h01);
    wr(8'h06, 8'h20);
    pin(0, 1'b1);
    pin(0, 1'b0);
    cnt_chk("p01 disabled", 0, 8'h00);
    wr(8'h06, 8'h00);
  endtask : t_irq

  task automatic t_ext;
    pin(1, 1'b1);
    cnt_chk("int1 rise", 1, 8'h01);
    pin(1, 1'b0);
    cnt_chk("int1 low", 1, 8'h00);
    wr(8'h08, 8'h20);
    pin(1, 1'b1);
    cnt_chk("int1 rise al", 1, 8'h00);
    pin(1, 1'b0);
    cnt_chk("int1 fall al", 1, 8'h01);
    wr(8'h08, 8'h01);
    wr(8'h00, 8'h08);
    ext_en[1] <= 1'b0;  // Released only while the pin is driven
    cnt_chk("int1 by output", 1, 8'h01);
    ext_en[1] <= 1'b1;
    wr(8'h08, 8'h00);
    pin(2, 1'b1);
    cnt_chk("int2 rise", 2, 8'h01);
    pin(2, 1'b0);
    wr(8'h00, 8'h00);
  endtask : t_ext

  task automatic t_usb;
    ext_en[4] <= 1'b0;
    ext_en[5] <= 1'b0;
    wr(8'h0D, 8'h01);
    wr(8'h0E, 8'h01);
    wr(8'h01, 8'h03);
    repeat (3) @(posedge sys_clk);
    #1 chk("dplus no high", 8'h01, {7'h00, pad_ctl[4].drv_n});
    pad_chk("dminus high", 5, 2'b01);
    wr(8'h01, 8'h00);
    pad_chk("dplus low", 4, 2'b00);
    usb_enable <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk("usb owns pins", 8'h03, {6'h00, pad_ctl[5].drv_n, pad_ctl[4].drv_n});
    usb_enable <= 1'b0;
    ext_en[4] <= 1'b1;
    ext_en[5] <= 1'b1;
    wr(8'h0D, 8'h02);
    wr(8'h0E, 8'h00);
    repeat (3) @(posedge sys_clk);
    #1 chk("usb pullups on", 8'h01, {7'h00, usb_pull});
    wr(8'h0D, 8'h00);
    repeat (3) @(posedge sys_clk);
    #1 chk("usb pullups off", 8'h00, {7'h00, usb_pull});
  endtask : t_usb

  task automatic t_alt;
    spi_oe_req <= 1'b1;
    spi_out <= 1'b1;
    reg_oe <= 1'b1;
    wr(8'h18, 8'h03);
    repeat (3) @(posedge sys_clk);
    #1 chk("alt funcs", 8'h04, {4'h0, ser_drv_n, ser_lvl, regp_drv_n, regp_lvl});
    wr(8'h18, 8'h04);
    repeat (3) @(posedge sys_clk);
    #1 chk("gpio off lv", 8'h0F, {4'h0, ser_drv_n, lv_drv, regp_drv_n, 1'b1});
    wr(8'h18, 8'h78);
    repeat (3) @(posedge sys_clk);
    #1 chk("gpio on", 8'h05, {4'h0, ser_drv_n, ser_lvl, regp_drv_n, regp_lvl});
    wr(8'h18, 8'h00);
  endtask : t_alt

  task automatic print_verdict;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_pads();
    t_irq();
    t_ext();
    t_usb();
    t_alt();
    print_verdict();
  end

  // Hang guard: far beyond the scripted run
  initial
  begin
    repeat (50000) @(posedge sys_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule : gpc_pin_config_test
`default_nettype wire
